//--- core/rvpoc_core.sv
// Register bank for reference IRQ clearing, phase offset stepping and validation
// Summary of operation
// - A one written to bit 6, 5 or 4 at 0x0A08 clears the second reference's validated, fault-cleared or fault IRQ bit.
// - A one written to bit 2, 1 or 0 at 0x0A08 clears the first reference's validated, fault-cleared or fault IRQ bit.
// - Clearing bits drop back to zero by themselves and each clear withdraws that event's interrupt request.
// - A one at bit 2 of 0x0A0A zeroes the accumulated incremental phase offset and then self-clears.
// - A one at bit 1 of 0x0A0A, with bits 2 and 0 clear, subtracts the programmed step size from the phase offset and self-clears.
// - A one at bit 0 of 0x0A0A, with bits 2 and 1 clear, adds the programmed step size to the phase offset and self-clears.
// - A one at bit 1 of 0x0A0B makes the second reference's validation timer act expired, then self-clears.
// - A one at bit 0 of 0x0A0B makes the first reference's validation timer act expired, then self-clears.
// - While bit 1 of 0x0A0C is set the second reference is invalid whatever its monitor says; reset value zero.
// - While bit 0 of 0x0A0C is set the first reference is invalid whatever its monitor says; reset value zero.
// - Bit 1 of 0x0A0D ignores the second reference's monitor and starts its validation timer; reset value zero.
// - Bit 0 of 0x0A0D ignores the first reference's monitor and starts its validation timer; reset value zero.
// - Bypass set first and force-timeout written later presents that reference as valid to the digital loop unless its override bit at 0x0A0C is set.
`timescale 1ns/1ps
`default_nettype none
`include "rvpoc_map.svh"

module rvpoc_core (
  input  wire logic                        sys_clk_in,
  input  wire logic                        arst_n_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  input  wire logic [`RVPOC_ADDR_W-1:0]    reg_addr_in,
  input  wire logic [`RVPOC_DATA_W-1:0]    reg_wdata_in,
  input  wire logic [`RVPOC_STEP_W-1:0]    step_size_in,
  input  wire logic [1:0]                  mon_fault_in,
  input  wire logic [1:0]                  timer_expired_in,
  output logic      [`RVPOC_DATA_W-1:0]    reg_rdata_out,
  output logic                             reg_rvalid_out,
  output logic      [`RVPOC_DATA_W-1:0]    irq_clear_out,
  output logic      [1:0]                  force_timeout_out,
  output logic      [1:0]                  mon_override_out,
  output logic      [1:0]                  mon_bypass_out,
  output logic      [1:0]                  timer_start_out,
  output logic      [1:0]                  fault_masked_out,
  output logic      [1:0]                  ref_valid_out,
  output logic      [`RVPOC_OFFSET_W-1:0]  phase_offset_out
);

  rvpoc_pkg::rvpoc_core_state_t st_reg;
  rvpoc_pkg::rvpoc_core_state_t st_next;

  logic                       wr_irq;
  logic                       wr_ph;
  logic                       wr_frc;
  logic                       wr_ovr;
  logic                       wr_byp;
  logic [`RVPOC_OFFSET_W-1:0] step_ext;

  assign wr_irq   = reg_wr_in & (reg_addr_in == `RVPOC_REF_IRQ_CLR_ADDR);
  assign wr_ph    = reg_wr_in & (reg_addr_in == `RVPOC_PHASE_CTL_ADDR);
  assign wr_frc   = reg_wr_in & (reg_addr_in == `RVPOC_FORCE_TMO_ADDR);
  assign wr_ovr   = reg_wr_in & (reg_addr_in == `RVPOC_MON_OVR_ADDR);
  assign wr_byp   = reg_wr_in & (reg_addr_in == `RVPOC_MON_BYP_ADDR);
  // Step size is a signed two's complement quantity
  assign step_ext = {{(`RVPOC_OFFSET_W-`RVPOC_STEP_W){step_size_in[`RVPOC_STEP_W-1]}},
                     step_size_in};

  always_comb begin
    st_next = st_reg;

    st_next.irq_clr = wr_irq ? (reg_wdata_in & `RVPOC_CLR_MASK) : `RVPOC_RESET_BYTE;

    st_next.ph_cmd = wr_ph ? reg_wdata_in[2:0] : 3'h0;

    st_next.force_tmo = wr_frc ? reg_wdata_in[1:0] : 2'h0;

    if (wr_ovr) begin
      st_next.mon_ovr = reg_wdata_in[1:0];
    end
    if (wr_byp) begin
      st_next.mon_byp = reg_wdata_in[1:0];
    end

    if (st_reg.ph_cmd[`RVPOC_PH_RESET_BIT]) begin
      st_next.offset = `RVPOC_RESET_OFFSET;
    end else begin
      if (st_reg.ph_cmd[`RVPOC_PH_DEC_BIT] & ~st_reg.ph_cmd[`RVPOC_PH_INC_BIT]) begin
        st_next.offset = st_reg.offset - step_ext;
      end
      if (st_reg.ph_cmd[`RVPOC_PH_INC_BIT] & ~st_reg.ph_cmd[`RVPOC_PH_DEC_BIT]) begin
        st_next.offset = st_reg.offset + step_ext;
      end
    end

    st_next.rd_valid = reg_rd_in;
    st_next.rd_data  = `RVPOC_RESET_BYTE;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `RVPOC_MON_OVR_ADDR: begin
          st_next.rd_data = {6'h00, st_reg.mon_ovr};
        end
        `RVPOC_MON_BYP_ADDR: begin
          st_next.rd_data = {6'h00, st_reg.mon_byp};
        end
        default: begin
          st_next.rd_data = `RVPOC_RESET_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `RVPOC_NUM_REFS; gi = gi + 1) begin : g_ref
      rvpoc_ref_qual u_qual (
        .sys_clk_in       (sys_clk_in),
        .arst_n_in        (arst_n_in),
        .force_pulse_in   (st_reg.force_tmo[gi]),
        .override_in      (st_reg.mon_ovr[gi]),
        .bypass_in        (st_reg.mon_byp[gi]),
        .mon_fault_in     (mon_fault_in[gi]),
        .timer_expired_in (timer_expired_in[gi]),
        .timer_start_out  (timer_start_out[gi]),
        .fault_masked_out (fault_masked_out[gi]),
        .ref_valid_out    (ref_valid_out[gi])
      );
    end
  endgenerate

  assign reg_rdata_out     = st_reg.rd_data;
  assign reg_rvalid_out    = st_reg.rd_valid;
  assign irq_clear_out     = st_reg.irq_clr;
  assign force_timeout_out = st_reg.force_tmo;
  assign mon_override_out  = st_reg.mon_ovr;
  assign mon_bypass_out    = st_reg.mon_byp;
  assign phase_offset_out  = st_reg.offset;

endmodule // rvpoc_core

`default_nettype wire

//--- core/rvpoc_ref_qual.sv
// Per-reference validity qualifier driven by override, bypass and force-timeout
`timescale 1ns/1ps
`default_nettype none

module rvpoc_ref_qual (
  input  wire logic sys_clk_in,
  input  wire logic arst_n_in,
  input  wire logic force_pulse_in,
  input  wire logic override_in,
  input  wire logic bypass_in,
  input  wire logic mon_fault_in,
  input  wire logic timer_expired_in,
  output logic      timer_start_out,
  output logic      fault_masked_out,
  output logic      ref_valid_out
);

  rvpoc_pkg::rvpoc_qual_state_t st_reg;
  rvpoc_pkg::rvpoc_qual_state_t st_next;

  logic eff_fault;

  always_comb begin
    st_next   = st_reg;
    eff_fault = mon_fault_in & ~bypass_in;
    st_next.byp_d = bypass_in;
    st_next.start = bypass_in & ~st_reg.byp_d;
    if (force_pulse_in) begin
      st_next.forced = 1'b1;
    end else if (override_in | eff_fault | (st_reg.byp_d & ~bypass_in)) begin
      st_next.forced = 1'b0;
    end
    st_next.valid = ~override_in &
                    (st_next.forced | (~eff_fault & timer_expired_in));
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign timer_start_out  = st_reg.start;
  assign fault_masked_out = override_in | eff_fault;
  assign ref_valid_out    = st_reg.valid;

endmodule // rvpoc_ref_qual

`default_nettype wire

//--- pkg/rvpoc_map.svh
// Register offsets, bit positions and widths of the reference validation block
`ifndef RVPOC_MAP_SVH
`define RVPOC_MAP_SVH

`define RVPOC_ADDR_W            16
`define RVPOC_DATA_W            8
`define RVPOC_OFFSET_W          32
`define RVPOC_STEP_W            16

`define RVPOC_REF_IRQ_CLR_ADDR  16'h0A08
`define RVPOC_RSV_IRQ_CLR_ADDR  16'h0A09
`define RVPOC_PHASE_CTL_ADDR    16'h0A0A
`define RVPOC_FORCE_TMO_ADDR    16'h0A0B
`define RVPOC_MON_OVR_ADDR      16'h0A0C
`define RVPOC_MON_BYP_ADDR      16'h0A0D

`define RVPOC_CLR_SECOND_VALID  6
`define RVPOC_CLR_SECOND_FCLR   5
`define RVPOC_CLR_SECOND_FAULT  4
`define RVPOC_CLR_FIRST_VALID   2
`define RVPOC_CLR_FIRST_FCLR    1
`define RVPOC_CLR_FIRST_FAULT   0
`define RVPOC_CLR_MASK          8'h77

`define RVPOC_PH_RESET_BIT      2
`define RVPOC_PH_DEC_BIT        1
`define RVPOC_PH_INC_BIT        0
`define RVPOC_PH_MASK           8'h07

`define RVPOC_REF_MASK          8'h03
`define RVPOC_NUM_REFS          2

`define RVPOC_RESET_BYTE        8'h00
`define RVPOC_RESET_OFFSET      32'h0000_0000

`endif

//--- pkg/rvpoc_pkg.sv
// Types of the reference validation and phase offset control block
`default_nettype none
`include "rvpoc_map.svh"

package rvpoc_pkg;

  typedef struct packed {
    logic [`RVPOC_DATA_W-1:0]   irq_clr;
    logic [2:0]                 ph_cmd;
    logic [1:0]                 force_tmo;
    logic [1:0]                 mon_ovr;
    logic [1:0]                 mon_byp;
    logic [`RVPOC_DATA_W-1:0]   rd_data;
    logic                       rd_valid;
    logic [`RVPOC_OFFSET_W-1:0] offset;
  } rvpoc_core_state_t;

  typedef struct packed {
    logic forced;
    logic byp_d;
    logic start;
    logic valid;
  } rvpoc_qual_state_t;

endpackage : rvpoc_pkg

`default_nettype wire

//--- verification/rvpoc_core_bench.sv
// Self-checking bench for the reference validation register bank
`timescale 1ns/1ps
`default_nettype none
module rvpoc_core_bench;
  logic        sys_clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic [15:0] step_size_in = 16'h0010;
  logic [1:0]  mon_fault_in = 2'b11;
  logic [1:0]  timer_expired_in = 2'b00;
  logic [7:0]  reg_rdata_out, irq_clear_out;
  logic        reg_rvalid_out;
  logic [1:0]  force_timeout_out, mon_override_out, mon_bypass_out;
  logic [1:0]  timer_start_out, fault_masked_out, ref_valid_out;
  logic [31:0] phase_offset_out;
  int          n_errors = 0;
  int          n_checks = 0;
  rvpoc_core dut_u (
    .sys_clk_in        (sys_clk_in),
    .arst_n_in         (arst_n_in),
    .reg_wr_in         (reg_wr_in),
    .reg_rd_in         (reg_rd_in),
    .reg_addr_in       (reg_addr_in),
    .reg_wdata_in      (reg_wdata_in),
    .step_size_in      (step_size_in),
    .mon_fault_in      (mon_fault_in),
    .timer_expired_in  (timer_expired_in),
    .reg_rdata_out     (reg_rdata_out),
    .reg_rvalid_out    (reg_rvalid_out),
    .irq_clear_out     (irq_clear_out),
    .force_timeout_out (force_timeout_out),
    .mon_override_out  (mon_override_out),
    .mon_bypass_out    (mon_bypass_out),
    .timer_start_out   (timer_start_out),
    .fault_masked_out  (fault_masked_out),
    .ref_valid_out     (ref_valid_out),
    .phase_offset_out  (phase_offset_out)
  );
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    step;
    cmp(reg_rvalid_out, 32'h0000_0001);
    cmp(reg_rdata_out, e);
  endtask
  task automatic ph(input logic [7:0] d, input logic [31:0] e);
    wr(16'h0A0A, d);
    step;
    step;
    cmp(phase_offset_out, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (800) @(posedge sys_clk_in);
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    rd(16'h0A0C, 8'h00);
    rd(16'h0A0D, 8'h00);
    wr(16'h0A08, 8'hFF);
    step;
    cmp(irq_clear_out, 8'h77);
    step;
    cmp(irq_clear_out, 8'h00);
    wr(16'h0A08, 8'h41);
    step;
    cmp(irq_clear_out, 8'h41);
    wr(16'h0A09, 8'hFF);
    step;
    cmp(irq_clear_out, 8'h00);
    rd(16'h0A09, 8'h00);
    rd(16'h0A08, 8'h00);
    wr(16'h0A0A, 8'h01);
    wr(16'h0A0A, 8'h01);
    step;
    step;
    cmp(phase_offset_out, 32'h0000_0020);
    ph(8'h02, 32'h0000_0010);
    ph(8'h03, 32'h0000_0010);
    @(posedge sys_clk_in);
    step_size_in <= 16'h8000;
    ph(8'h01, 32'hFFFF_8010);
    ph(8'hFF, 32'h0000_0000);
    wr(16'h0A0D, 8'h03);
    step;
    cmp(mon_bypass_out, 2'b11);
    cmp(fault_masked_out, 2'b00);
    step;
    cmp(timer_start_out, 2'b11);
    wr(16'h0A0B, 8'h03);
    step;
    cmp(force_timeout_out, 2'b11);
    cmp(timer_start_out, 2'b00);
    step;
    cmp(force_timeout_out, 2'b00);
    cmp(ref_valid_out, 2'b11);
    rd(16'h0A0B, 8'h00);
    rd(16'h0A0D, 8'h03);
    wr(16'h0A0C, 8'hFE);
    step;
    step;
    cmp(ref_valid_out, 2'b01);
    cmp(fault_masked_out, 2'b10);
    rd(16'h0A0C, 8'h02);
    wr(16'h0A0C, 8'h01);
    step;
    step;
    cmp(ref_valid_out, 2'b00);
    @(posedge sys_clk_in);
    mon_fault_in <= 2'b10;
    timer_expired_in <= 2'b11;
    step;
    cmp(ref_valid_out, 2'b10);
    cmp(fault_masked_out, 2'b01);
    wr(16'h0A0D, 8'h00);
    step;
    cmp(fault_masked_out, 2'b11);
    step;
    cmp(ref_valid_out, 2'b00);
    ph(8'h01, 32'hFFFF_8000);
    @(posedge sys_clk_in);
    arst_n_in <= 1'b0;
    step;
    cmp(mon_override_out, 2'b00);
    cmp(phase_offset_out, 32'h0000_0000);
    @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    rd(16'h0A0C, 8'h00);
    cmp(ref_valid_out, 2'b01);
    report_and_stop;
  end
endmodule // rvpoc_core_bench
bind rvpoc_core rvpoc_core_sva chk_u (
  .sys_clk_in        (sys_clk_in),
  .arst_n_in         (arst_n_in),
  .reg_wr_in         (reg_wr_in),
  .reg_rd_in         (reg_rd_in),
  .reg_addr_in       (reg_addr_in),
  .reg_wdata_in      (reg_wdata_in),
  .step_size_in      (step_size_in),
  .mon_fault_in      (mon_fault_in),
  .timer_expired_in  (timer_expired_in),
  .reg_rdata_out     (reg_rdata_out),
  .reg_rvalid_out    (reg_rvalid_out),
  .irq_clear_out     (irq_clear_out),
  .force_timeout_out (force_timeout_out),
  .mon_override_out  (mon_override_out),
  .mon_bypass_out    (mon_bypass_out),
  .timer_start_out   (timer_start_out),
  .fault_masked_out  (fault_masked_out),
  .ref_valid_out     (ref_valid_out),
  .phase_offset_out  (phase_offset_out)
);
`default_nettype wire

//--- verification/rvpoc_core_sva.sv
// Concurrent checks on the reference validation register bank
`timescale 1ns/1ps
`default_nettype none
module rvpoc_core_sva (
  input wire logic        sys_clk_in,
  input wire logic        arst_n_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [15:0] step_size_in,
  input wire logic [1:0]  mon_fault_in,
  input wire logic [1:0]  timer_expired_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic [7:0]  irq_clear_out,
  input wire logic [1:0]  force_timeout_out,
  input wire logic [1:0]  mon_override_out,
  input wire logic [1:0]  mon_bypass_out,
  input wire logic [1:0]  timer_start_out,
  input wire logic [1:0]  fault_masked_out,
  input wire logic [1:0]  ref_valid_out,
  input wire logic [31:0] phase_offset_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire logic clr_w = reg_wr_in && reg_addr_in == 16'h0A08;
  wire logic ph_w  = reg_wr_in && reg_addr_in == 16'h0A0A;
  wire logic frc_w = reg_wr_in && reg_addr_in == 16'h0A0B;
  wire logic ovr_w = reg_wr_in && reg_addr_in == 16'h0A0C;
  wire logic byp_w = reg_wr_in && reg_addr_in == 16'h0A0D;
  chk_irq_clear: assert property (
    1 |=> irq_clear_out == ($past(clr_w) ? $past(reg_wdata_in) & 8'h77 : 8'h00))
    else $error("clear pulse wrong");
  chk_force_pulse: assert property (
    1 |=> force_timeout_out == ($past(frc_w) ? $past(reg_wdata_in[1:0]) : 2'b00))
    else $error("force pulse wrong");
  chk_ovr_write: assert property (
    ovr_w |=> mon_override_out == $past(reg_wdata_in[1:0])) else $error("override wrong");
  chk_byp_write: assert property (
    byp_w |=> mon_bypass_out == $past(reg_wdata_in[1:0])) else $error("bypass wrong");
  chk_ovr_invalid: assert property (
    1 |-> (ref_valid_out & mon_override_out & $past(mon_override_out)) == 2'b00)
    else $error("overridden ref valid");
  chk_phase_zero: assert property (
    ph_w && reg_wdata_in[2] |=> ##1 phase_offset_out == 32'h0000_0000)
    else $error("offset not zeroed");
  chk_phase_inc: assert property (
    ph_w && reg_wdata_in[2:0] == 3'b001 |=> ##1 phase_offset_out ==
      $past(phase_offset_out) + {{16{$past(step_size_in[15])}}, $past(step_size_in)})
    else $error("offset not stepped");
  chk_byp_force: assert property (
    mon_bypass_out[0] && force_timeout_out[0] && !mon_override_out[0] |=> ref_valid_out[0])
    else $error("forced ref not valid");
  chk_phase_dec: assert property (
    ph_w && reg_wdata_in[2:0] == 3'b010 |=> ##1 phase_offset_out ==
      $past(phase_offset_out) - {{16{$past(step_size_in[15])}}, $past(step_size_in)})
    else $error("offset not decremented");
  chk_timer_start: assert property (
    byp_w && reg_wdata_in[0] && !mon_bypass_out[0] |=> ##1 timer_start_out[0])
    else $error("timer start missing");
  chk_rsvd_read: assert property (
    reg_rd_in && reg_addr_in != 16'h0A0C && reg_addr_in != 16'h0A0D |=>
      reg_rvalid_out && reg_rdata_out == 8'h00)
    else $error("reserved read not zero");
endmodule // rvpoc_core_sva
`default_nettype wire
